// file: data_sync.sv
// Two flip-flop synchroniser for the data bus read back
`timescale 1ns/1ps
module data_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // data_sync

// file: test_vram_host.sv
// Self-checking testbench for the video DRAM host controller
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  err_total++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_vram_host;
  import vram_host_pkg::*;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] dq, bus;
  vram_pins_s pins;
  int err_total, checks_done;

  vram_host dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .data_mask_bus_in(bus));
  vram_device_model mem_model (.pins(pins), .bus(bus), .dq(dq));
  // Resolved data bus
  assign bus = pins.data_mask_bus_oe ? pins.data_mask_bus_out : dq;

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // One APB transfer
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask

  // Start a command, wait for idle
  task automatic run(input logic [3:0] c, input logic [3:0] f,
    input logic [8:0] r, input logic [8:0] k, input logic [15:0] d);
    apb(1'b1, OFS_ADDR, {7'h00, k, 7'h00, r});
    apb(1'b1, OFS_WDATA, {16'h0000, d});
    apb(1'b1, OFS_CTRL, {20'h00000, f, c, 4'h1});
    repeat (2) @(posedge core_clk);
    do apb(1'b0, OFS_STATUS, 32'h0); while (q[STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic rd_mem(input logic [8:0] r, input logic [8:0] k,
                        input logic [15:0] e);
    run(CMD_READ, 4'h0, r, k, 16'h0000);
    rd_chk(OFS_RDATA, {16'h0000, e});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(OFS_MASK, {16'h0000, MASK_RESET});
    apb(1'b0, 8'h18, 32'h0);
    `CHK(perr, 1'b1)
  endtask

  task automatic t_write();
    run(CMD_WRITE_EARLY, 4'h3, 9'h005, 9'h009, 16'ha5c3);
    rd_mem(9'h005, 9'h009, 16'ha5c3);
    run(CMD_WRITE_LATE, 4'h1, 9'h005, 9'h009, 16'h1234);
    rd_mem(9'h005, 9'h009, 16'h12c3);
    run(CMD_WRITE_LATE, 4'h3, 9'h005, 9'h009, 16'h5566);
    rd_mem(9'h005, 9'h009, 16'h5566);
    run(CMD_RMW, 4'h3, 9'h005, 9'h009, 16'h9abc);
    rd_chk(OFS_RDATA, 32'h5566);
    rd_mem(9'h005, 9'h009, 16'h9abc);
  endtask

  task automatic t_fill();
    run(CMD_COLOR_SET, 4'h0, 9'h007, 9'h000, 16'hbeef);
    run(CMD_BLOCK, 4'h3, 9'h007, 9'h013, 16'h0405);
    rd_mem(9'h007, 9'h010, 16'h00ef);
    rd_mem(9'h007, 9'h011, 16'h0000);
    rd_mem(9'h007, 9'h012, 16'hbeef);
    run(CMD_COLOR_SET, 4'h0, 9'h009, 9'h000, 16'h1357);
    run(CMD_FLASH, 4'h1, 9'h009, 9'h000, 16'h0000);
    rd_mem(9'h009, 9'h1ff, 16'h1300);
    rd_mem(9'h009, 9'h000, 16'h1300);
  endtask

  task automatic t_mask();
    run(CMD_WRITE_EARLY, 4'h7, 9'h005, 9'h009, 16'hffff);
    rd_chk(OFS_STATUS, 32'h4);
    rd_mem(9'h005, 9'h009, 16'h9abc);
    apb(1'b1, OFS_STATUS, 32'h4);
    run(CMD_CBR_RESET, 4'h0, 9'h000, 9'h000, 16'h0000);
    rd_chk(OFS_STATUS, 32'h8);
    apb(1'b1, OFS_MASK, 32'h00ff);
    rd_chk(OFS_MASK, 32'h00ff);
    run(CMD_WRITE_EARLY, 4'h7, 9'h005, 9'h009, 16'hffff);
    rd_mem(9'h005, 9'h009, 16'h9aff);
  endtask

  task automatic t_misc();
    cmd_e list [5] = '{CMD_XFER_READ, CMD_XFER_WRITE, CMD_CBR_KEEP,
                       CMD_CBR_STOP, CMD_RAS_ONLY};
    foreach (list[i]) begin
      run(list[i], 4'h0, 9'h005, 9'h000, 16'h0000);
      rd_chk(OFS_STATUS, 32'h8);
    end
    rd_mem(9'h005, 9'h009, 16'h9aff);
  endtask

  task automatic t_page();
    run(CMD_READ, 4'h8, 9'h005, 9'h009, 16'h0000);
    rd_chk(OFS_RDATA, 32'h9aff);
    rd_chk(OFS_STATUS, 32'ha);
    run(CMD_WRITE_EARLY, 4'hb, 9'h005, 9'h00a, 16'h4242);
    rd_mem(9'h005, 9'h00a, 16'h4242);
    rd_chk(OFS_STATUS, 32'h8);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #(20 * 60000);
    err_total++;
    end_of_test();
  end

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_write();
    t_fill();
    t_mask();
    t_misc();
    t_page();
    end_of_test();
  end
endmodule // test_vram_host

// file: vram_device_model.sv
// Behavioural model of the video DRAM random access port
`timescale 1ns/1ps
module vram_device_model import vram_host_pkg::*; (
  // Controller pins
  input wire vram_host_pkg::vram_pins_s pins,
  // Resolved data bus
  input wire logic [15:0] bus,
  // Data the device offers on the bus
  output logic [15:0] dq
);
  logic [15:0] mem [logic [17:0]];
  logic [15:0] color, wmask, lanes, wd;
  logic [8:0] row, col, stop;
  logic cbr, xfer, sfs_r, msk, blk, wd_ok;
  wire ras = pins.row_strobe_n;
  wire cas = pins.column_strobe_n;
  wire oe = pins.transfer_output_enable_n;
  wire up_n = pins.upper_write_enable_n;
  wire lo_n = pins.lower_write_enable_n;
  wire sfs = pins.special_function_select;
  wire [8:0] adr = pins.multiplexed_address_bus;
  wire rd_on = !ras && !cas && !oe && !xfer && !cbr && !sfs_r;

  initial begin
    color = 16'h0000;
    wmask = 16'hffff;
    dq = 16'h0000;
  end

  function automatic logic [15:0] get(input logic [8:0] c);
    return mem.exists({row, c}) ? mem[{row, c}] : 16'h0000;
  endfunction

  // Enabled bytes, narrowed by the write lanes
  function automatic logic [15:0] ben();
    return {{8{!up_n}}, {8{!lo_n}}} & lanes;
  endfunction

  task automatic put(input logic [8:0] c, input logic [15:0] d,
                     input logic [15:0] en);
    mem[{row, c}] = (get(c) & ~en) | (d & en);
  endtask

  // Column selects gate eight columns
  task automatic block_wr();
    for (int n = 0; n < 8; n++) begin
      put({col[8:3], 3'(n)}, color, ben() & {{8{bus[n+8]}}, {8{bus[n]}}});
    end
    blk = 1'b0;
  endtask

  // Row fall latches row and mode
  always @(negedge ras) begin
    row = adr;
    cbr = !cas;
    xfer = !oe;
    sfs_r = sfs;
    msk = !cbr && !xfer && !(up_n && lo_n);
    lanes = !msk ? 16'hffff : (pins.data_mask_bus_oe ? bus : wmask);
    if (cbr && !sfs) stop = 9'h1ff;
    if (cbr && sfs && !up_n) stop = adr;
    if (msk && sfs) for (int c = 0; c < 512; c++) put(9'(c), color, ben());
  end

  // Column fall: register set, block or early write
  always @(negedge cas) if (!ras && !cbr && !xfer) begin
    col = adr;
    wd = bus;
    wd_ok = !(up_n && lo_n);
    blk = sfs && !sfs_r;
    if (sfs_r && !msk) begin
      if (sfs) color = bus;
      else wmask = bus;
    end else if (blk && wd_ok) block_wr();
    else if (wd_ok) put(col, bus, ben());
  end

  // Late enable stores its byte of the latched word
  always @(negedge up_n or negedge lo_n) begin
    if (!ras && !cas && !msk && !xfer && !cbr) begin
      if (!wd_ok) wd = bus;
      wd_ok = 1'b1;
      if (blk) block_wr();
      else put(col, wd, ben());
    end
  end

  // Column precharge ends the write latch
  always @(posedge cas) begin
    wd_ok = 1'b0;
    blk = 1'b0;
  end

  // Read word driven, released lines invert
  always @(rd_on or col or row) begin
    if (rd_on) dq = get(col);
    else dq = ~dq;
  end
endmodule // vram_device_model

// file: vram_host.sv
// Host controller that runs random port cycles on a dual port video DRAM
// Operation
// RL1: Mode chosen by levels at strobe falls
// RL2: Column strobe first gives internal refresh
// RL3: Optional reset sets boundary register ones
// RL4: Output enable low at row fall: transfer
// RL5: Read word driven while output enable low
// RL6: Special function low at row fall reading
// RL7: Page read output held until next fall
// RL8: Several column cycles within one row
// RL9: Full word latched, enabled bytes stored
// RL10: Later second enable stores other byte
// RL11: Write enables high at row fall unmasked
// RL12: Early write: enables before column strobe
// RL13: Late write: enables after, output disabled
// RL14: Modify data only after output released
// RL15: Flash write fills row with color
// RL16: Block write fills eight columns
// RL17: Data pins carry block column selects
// RL18: Column selects sampled at last fall
// RL19: Register set picks color or mask
// RL20: Mask writes only after mask selection
// RL21: Row only refresh keeps all state
// RL22: Mask write bit lanes from data pins
// RL23: Block group ignores low column bits
`timescale 1ns/1ps
module vram_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory pins
  output vram_host_pkg::vram_pins_s pins,
  input wire logic [15:0] data_mask_bus_in
);
  import vram_host_pkg::*;

  typedef enum {
    S_IDLE, S_RAS_SET, S_RAS_LOW, S_CAS_SET, S_CAS_LOW, S_OE_LOW,
    S_TURN, S_WE_LOW, S_CAS_HIGH, S_RAS_HIGH
  } state_e;

  // ----------
  // Declarations
  // ----------
  logic [15:0] data_in_sync;
  logic [31:0] ctrl, next_ctrl, addr_reg, next_addr_reg;
  logic [15:0] wdata, next_wdata, mask, next_mask;
  logic start, next_start, refused, next_refused;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  state_e state, next_state;
  vram_pins_s next_pins;
  logic [3:0] cnt, next_cnt;
  logic [15:0] rdata, next_rdata;
  logic row_open, next_row_open, reopen, next_reopen;
  logic mask_armed, next_mask_armed;
  logic [8:0] open_row, next_open_row;
  cmd_e cmd;
  logic up_sel, lo_sel, masked, keep_row, is_col, legal, busy, wr, setup;
  logic [8:0] row, col;
  logic [15:0] stat;

  data_sync #(.WIDTH(16)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .din(data_mask_bus_in),
    .dout(data_in_sync)
  );

  // Command field decode
  assign cmd = cmd_e'(ctrl[CTRL_CMD_LSB +: 4]);
  assign up_sel = ctrl[CTRL_UPPER_BIT];
  assign lo_sel = ctrl[CTRL_LOWER_BIT];
  assign masked = ctrl[CTRL_MASKED_BIT];
  assign keep_row = ctrl[CTRL_KEEP_ROW_BIT];
  assign row = addr_reg[ADDR_ROW_LSB +: 9];
  assign col = addr_reg[ADDR_COL_LSB +: 9];
  assign is_col = (cmd == CMD_READ) || (cmd == CMD_WRITE_EARLY) ||
                  (cmd == CMD_WRITE_LATE) || (cmd == CMD_RMW) ||
                  (cmd == CMD_BLOCK);
  assign busy = start || (state != S_IDLE);
  assign wr = psel && penable && pwrite && pready;
  assign setup = psel && !penable;
  assign stat = {12'h000, mask_armed, refused, row_open, busy};

  // ----------
  // APB register file
  // ----------
  // Next register values and read data
  always_comb begin
    next_ctrl = ctrl;
    next_addr_reg = addr_reg;
    next_wdata = wdata;
    next_mask = mask;
    next_start = 1'b0;
    next_refused = refused;
    next_pready = setup;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    legal = pwdata[CTRL_CMD_LSB +: 4] <= CMD_RAS_ONLY;
    if (setup && !pwrite) begin
      unique case (paddr)
        OFS_CTRL: next_prdata = ctrl;
        OFS_ADDR: next_prdata = addr_reg;
        OFS_WDATA: next_prdata = {16'h0000, wdata};
        OFS_MASK: next_prdata = {16'h0000, mask};
        OFS_RDATA: next_prdata = {16'h0000, rdata};
        OFS_STATUS: next_prdata = {16'h0000, stat};
        default: next_pslverr = 1'b1;
      endcase
    end else if (setup) begin
      next_pslverr = !(paddr inside {OFS_CTRL, OFS_ADDR, OFS_WDATA,
                                     OFS_MASK, OFS_RDATA, OFS_STATUS});
    end
    if (wr && paddr == OFS_STATUS && pwdata[STAT_REFUSED_BIT]) begin
      next_refused = 1'b0;
    end
    if (wr && paddr == OFS_ADDR) next_addr_reg = pwdata;
    if (wr && paddr == OFS_WDATA) next_wdata = pwdata[15:0];
    if (wr && paddr == OFS_MASK) next_mask = pwdata[15:0];
    if (wr && paddr == OFS_CTRL && pwdata[CTRL_GO_BIT]) begin
      // Mask writes refused until a mask selection cycle [RL20]
      if (busy || !legal || (pwdata[CTRL_MASKED_BIT] && !mask_armed)) begin
        next_refused = 1'b1;
      end else begin
        next_ctrl = pwdata;
        next_start = 1'b1;
      end
    end
  end

  // Register the bus group
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= 32'h0000_0000;
      addr_reg <= 32'h0000_0000;
      wdata <= 16'h0000;
      mask <= MASK_RESET;
      start <= 1'b0;
      refused <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      addr_reg <= next_addr_reg;
      wdata <= next_wdata;
      mask <= next_mask;
      start <= next_start;
      refused <= next_refused;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------
  // Strobe sequencer
  // ----------
  // Next state, pin levels and captured data
  always_comb begin
    next_state = state;
    next_pins = pins;
    next_cnt = (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
    next_rdata = rdata;
    next_row_open = row_open;
    next_reopen = reopen;
    next_open_row = open_row;
    next_mask_armed = mask_armed;
    unique case (state)
      S_IDLE: begin
        if (start) begin
          next_cnt = PHASE_LOAD;
          if (cmd == CMD_MASK_SET || cmd == CMD_CBR_RESET) begin
            next_mask_armed = 1'b1; // [RL20]
          end
          if (row_open && is_col && row == open_row) begin
            next_state = S_CAS_SET; // Page cycle on open row [RL8]
          end else if (row_open) begin
            next_reopen = 1'b1;
            next_row_open = 1'b0;
            next_pins.row_strobe_n = 1'b1;
            next_state = S_RAS_HIGH;
          end else begin
            next_state = S_RAS_SET;
          end
        end
      end
      S_RAS_SET: begin
        // Levels that the row strobe fall will sample [RL1]
        next_pins = PINS_IDLE;
        next_pins.multiplexed_address_bus = row; // Row or stop data [RL2]
        next_pins.column_strobe_n = !(cmd inside {CMD_CBR_RESET,
                                    CMD_CBR_KEEP, CMD_CBR_STOP}); // [RL2]
        next_pins.transfer_output_enable_n = !(cmd inside {CMD_XFER_READ,
                                             CMD_XFER_WRITE}); // [RL4]
        // Special function low on reads, high for split, flash, sets
        next_pins.special_function_select = cmd inside {CMD_FLASH,
          CMD_COLOR_SET, CMD_MASK_SET, CMD_CBR_KEEP, CMD_CBR_STOP} ||
          (cmd inside {CMD_XFER_READ, CMD_XFER_WRITE} && masked); // [RL6]
        // Enables high unless masked column cycle, flash, stop set or write transfer
        if (cmd inside {CMD_CBR_STOP, CMD_XFER_WRITE}) begin
          next_pins.upper_write_enable_n = 1'b0; // [RL4]
          next_pins.lower_write_enable_n = 1'b0;
        end else if (cmd == CMD_FLASH || (masked && is_col)) begin
          next_pins.upper_write_enable_n = !up_sel; // [RL11] [RL15]
          next_pins.lower_write_enable_n = !lo_sel;
        end
        if (masked && cmd != CMD_CBR_STOP) begin
          next_pins.data_mask_bus_out = mask; // Per-cycle lanes [RL22]
          next_pins.data_mask_bus_oe = 1'b1;
        end
        if (cnt == 4'h0) begin
          next_pins.row_strobe_n = 1'b0;
          next_cnt = PHASE_LOAD;
          next_state = S_RAS_LOW;
        end
      end
      S_RAS_LOW: begin
        if (cnt == 4'h0) begin
          next_pins.upper_write_enable_n = 1'b1;
          next_pins.lower_write_enable_n = 1'b1;
          next_pins.transfer_output_enable_n = 1'b1;
          next_pins.data_mask_bus_oe = 1'b0;
          next_cnt = PHASE_LOAD;
          next_open_row = row;
          if (cmd inside {CMD_CBR_RESET, CMD_CBR_KEEP, CMD_CBR_STOP,
                          CMD_RAS_ONLY, CMD_FLASH}) begin
            // No column cycle: refresh or whole-row flash [RL21] [RL15]
            next_pins = PINS_IDLE;
            next_state = S_RAS_HIGH;
          end else begin
            next_state = S_CAS_SET;
          end
        end
      end
      S_CAS_SET: begin
        next_pins.multiplexed_address_bus = col;
        // Special function at column fall picks block or color [RL19]
        next_pins.special_function_select = cmd inside {CMD_BLOCK,
                                                        CMD_COLOR_SET};
        if (cmd == CMD_BLOCK) begin
          next_pins.multiplexed_address_bus = {col[8:3], 3'h0}; // [RL23]
        end
        if (cmd inside {CMD_WRITE_EARLY, CMD_BLOCK, CMD_COLOR_SET,
                        CMD_MASK_SET}) begin
          // Data or column selects valid before the last fall [RL17]
          next_pins.data_mask_bus_out = wdata; // [RL16] [RL18]
          next_pins.data_mask_bus_oe = 1'b1;
          if (cmd inside {CMD_WRITE_EARLY, CMD_BLOCK}) begin
            next_pins.upper_write_enable_n = !up_sel; // [RL12] [RL9]
            next_pins.lower_write_enable_n = !lo_sel;
          end else begin
            next_pins.upper_write_enable_n = 1'b0;
            next_pins.lower_write_enable_n = 1'b0;
          end
        end
        if (cnt == 4'h0) begin
          next_pins.column_strobe_n = 1'b0; // Column strobe falls last
          next_cnt = PHASE_LOAD;
          next_state = S_CAS_LOW;
        end
      end
      S_CAS_LOW: begin
        if (cnt == 4'h0) begin
          if (cmd inside {CMD_READ, CMD_RMW}) begin
            next_pins.transfer_output_enable_n = 1'b0; // [RL5]
            next_cnt = READ_LOAD;
            next_state = S_OE_LOW;
          end else if (cmd == CMD_WRITE_LATE) begin
            // Output enable stays high, enables fall after column [RL13]
            next_pins.data_mask_bus_out = wdata;
            next_pins.data_mask_bus_oe = 1'b1;
            next_pins.upper_write_enable_n = !up_sel;
            next_pins.lower_write_enable_n = up_sel || !lo_sel;
            next_cnt = PHASE_LOAD;
            next_state = S_WE_LOW;
          end else begin
            next_pins.column_strobe_n = 1'b1;
            next_pins.upper_write_enable_n = 1'b1;
            next_pins.lower_write_enable_n = 1'b1;
            next_pins.data_mask_bus_oe = 1'b0;
            next_cnt = PHASE_LOAD;
            next_state = S_CAS_HIGH;
          end
        end
      end
      S_OE_LOW: begin
        if (cnt == 4'h0) begin
          // Word held by the part while enable low [RL5] [RL7]
          next_rdata = data_in_sync;
          next_pins.transfer_output_enable_n = 1'b1;
          if (cmd == CMD_RMW) begin
            next_cnt = TURN_LOAD;
            next_state = S_TURN;
          end else begin
            next_pins.column_strobe_n = 1'b1;
            next_cnt = PHASE_LOAD;
            next_state = S_CAS_HIGH;
          end
        end
      end
      S_TURN: begin
        if (cnt == 4'h0) begin
          // Drive modified data only after outputs released [RL14]
          next_pins.data_mask_bus_out = wdata;
          next_pins.data_mask_bus_oe = 1'b1;
          next_pins.upper_write_enable_n = !up_sel;
          next_pins.lower_write_enable_n = up_sel || !lo_sel;
          next_cnt = PHASE_LOAD;
          next_state = S_WE_LOW;
        end
      end
      S_WE_LOW: begin
        if (cnt == 4'h0) begin
          next_cnt = PHASE_LOAD;
          if (up_sel && lo_sel && pins.lower_write_enable_n) begin
            next_pins.lower_write_enable_n = 1'b0; // Other byte [RL10]
          end else begin
            next_pins.column_strobe_n = 1'b1;
            next_pins.upper_write_enable_n = 1'b1;
            next_pins.lower_write_enable_n = 1'b1;
            next_pins.data_mask_bus_oe = 1'b0;
            next_state = S_CAS_HIGH;
          end
        end
      end
      S_CAS_HIGH: begin
        if (cnt == 4'h0) begin
          if (keep_row && is_col) begin
            next_row_open = 1'b1; // Row stays open for page cycles [RL8]
            next_state = S_IDLE;
          end else begin
            next_row_open = 1'b0; // Closing the row ends page mode
            next_pins = PINS_IDLE;
            next_cnt = PHASE_LOAD;
            next_state = S_RAS_HIGH;
          end
        end
      end
      S_RAS_HIGH: begin
        if (cnt == 4'h0) begin
          next_pins = PINS_IDLE;
          next_cnt = PHASE_LOAD;
          next_reopen = 1'b0;
          next_state = reopen ? S_RAS_SET : S_IDLE;
        end
      end
    endcase
  end

  // Register the sequencer group
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_IDLE;
      pins <= PINS_IDLE;
      cnt <= 4'h0;
      rdata <= 16'h0000;
      row_open <= 1'b0;
      reopen <= 1'b0;
      open_row <= 9'h000;
      mask_armed <= 1'b0;
    end else begin
      state <= next_state;
      pins <= next_pins;
      cnt <= next_cnt;
      rdata <= next_rdata;
      row_open <= next_row_open;
      reopen <= next_reopen;
      open_row <= next_open_row;
      mask_armed <= next_mask_armed;
    end
  end
endmodule // vram_host

// file: vram_host_pkg.sv
// Constants, commands and pin bundle for the video DRAM host controller
package vram_host_pkg;

  // ----------
  // Timing
  // ----------
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_PHASE_NS = 40;
  localparam int T_TURN_NS = 20;
  localparam int SYNC_CYC = 2;
  localparam int PHASE_CYC = (T_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC = (T_TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PHASE_LOAD = 4'(PHASE_CYC - 1);
  localparam logic [3:0] TURN_LOAD = 4'(TURN_CYC - 1);
  localparam logic [3:0] READ_LOAD = 4'(PHASE_CYC + SYNC_CYC - 1);

  // ----------
  // Register offsets and fields
  // ----------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_CMD_LSB = 4;
  localparam int CTRL_UPPER_BIT = 8;
  localparam int CTRL_LOWER_BIT = 9;
  localparam int CTRL_MASKED_BIT = 10;
  localparam int CTRL_KEEP_ROW_BIT = 11;
  localparam int ADDR_ROW_LSB = 0;
  localparam int ADDR_COL_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ROW_OPEN_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_MASK_ARMED_BIT = 3;
  localparam logic [15:0] MASK_RESET = 16'hffff;

  // ----------
  // Commands (software visible codes)
  // ----------
  typedef enum logic [3:0] {
    CMD_READ = 4'h0,
    CMD_WRITE_EARLY = 4'h1,
    CMD_WRITE_LATE = 4'h2,
    CMD_RMW = 4'h3,
    CMD_BLOCK = 4'h4,
    CMD_FLASH = 4'h5,
    CMD_COLOR_SET = 4'h6,
    CMD_MASK_SET = 4'h7,
    CMD_XFER_READ = 4'h8,
    CMD_XFER_WRITE = 4'h9,
    CMD_CBR_RESET = 4'ha,
    CMD_CBR_KEEP = 4'hb,
    CMD_CBR_STOP = 4'hc,
    CMD_RAS_ONLY = 4'hd
  } cmd_e;

  // ----------
  // Memory pins driven by the controller
  // ----------
  typedef struct packed {
    logic row_strobe_n;
    logic column_strobe_n;
    logic transfer_output_enable_n;
    logic upper_write_enable_n;
    logic lower_write_enable_n;
    logic special_function_select;
    logic [8:0] multiplexed_address_bus;
    logic [15:0] data_mask_bus_out;
    logic data_mask_bus_oe;
  } vram_pins_s;

  localparam vram_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
                                       9'h000, 16'h0000, 1'b0};

endpackage

// file: vram_host_properties.sv
// Port checks for the video DRAM host controller
`timescale 1ns/1ps
module vram_host_properties import vram_host_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Memory pins
  input wire vram_host_pkg::vram_pins_s pins
);
  logic row_q, cas_q, sfs_row, oe_row, we_row, armed;
  wire ras_n = pins.row_strobe_n;
  wire cas_n = pins.column_strobe_n;
  wire oe_n = pins.transfer_output_enable_n;
  wire up_n = pins.upper_write_enable_n;
  wire lo_n = pins.lower_write_enable_n;
  wire sfs = pins.special_function_select;
  wire bus_oe = pins.data_mask_bus_oe;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Levels at the last row fall and the mask selection state
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      row_q <= 1'b1;
      cas_q <= 1'b1;
      sfs_row <= 1'b0;
      oe_row <= 1'b1;
      we_row <= 1'b1;
      armed <= 1'b0;
    end else begin
      row_q <= ras_n;
      cas_q <= cas_n;
      if (row_q && !ras_n) begin
        sfs_row <= sfs;
        oe_row <= oe_n;
        we_row <= up_n && lo_n;
        if (!cas_n && !sfs) armed <= 1'b1;
      end
      if (cas_q && !cas_n && !ras_n && sfs_row && we_row && oe_row && !sfs)
        armed <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Strobe levels
  // ----------------------------------------------------------------------
  sequence s_row_fall;
    $fell(ras_n) && cas_n && oe_n;
  endsequence
  property p_row_levels;
    $fell(ras_n) |-> $stable({cas_n, oe_n, up_n, lo_n, sfs})
      && $stable(pins.multiplexed_address_bus);
  endproperty
  a_row_levels: assert property (p_row_levels)
    else $error("row levels moved");
  property p_col_levels;
    $fell(cas_n) && !ras_n |->
      $stable(sfs) && $stable(pins.multiplexed_address_bus);
  endproperty
  a_col_levels: assert property (p_col_levels)
    else $error("column levels moved");
  property p_early;
    $fell(cas_n) && !ras_n && we_row && oe_row && !(up_n && lo_n)
      |-> bus_oe;
  endproperty
  a_early: assert property (p_early)
    else $error("early write without data");
  property p_late;
    $fell(up_n) && !cas_n && !ras_n |-> bus_oe && oe_n;
  endproperty
  a_late: assert property (p_late)
    else $error("late write bus or enable wrong");
  property p_no_clash;
    !oe_n && !ras_n && !cas_n && oe_row |-> !bus_oe;
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("bus clash during read");
  property p_read_sfs;
    $fell(oe_n) && !ras_n |-> !sfs_row;
  endproperty
  a_read_sfs: assert property (p_read_sfs)
    else $error("read with function select high");
  property p_mask_armed;
    s_row_fall ##0 (!sfs && !(up_n && lo_n)) |-> armed;
  endproperty
  a_mask_armed: assert property (p_mask_armed)
    else $error("mask write before selection");

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready not one cycle");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err)
    else $error("error without ready");
endmodule // vram_host_properties

bind vram_host vram_host_properties u_props (.core_clk(core_clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .pins(pins));
